//--- single_wire_brightness_receiver_tb.sv
// Purpose: Self-checking bench for both ends of the brightness link.
// Assumes: 50 MHz clock; a second link is driven by the bench itself.
// Notes: The second link sends short and overlong frames on purpose.
`timescale 1ns/1ps
module single_wire_brightness_receiver_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic send = 1'b0;
  logic [4:0] code = 5'h0;
  logic enable = 1'b0;
  logic over_temp = 1'b0;
  logic busy;
  logic [4:0] bright;
  logic [4:0] bright_b;
  logic valid;
  logic req;
  int num_errors = 0;
  int checked = 0;
  int nvalid = 0;
  logic [4:0] codes [4] = '{5'h0a, 5'h15, 5'h01, 5'h00};
  swb_if link ();
  swb_if bad ();
  always #10 clk = ~clk;
  swb_tx i_swb_tx (.clk, .rst_n, .link(link), .send, .code, .busy);
  swb_rx i_swb_rx (.clk, .rst_n, .link(link), .enable, .over_temp,
    .brightness_code(bright), .code_valid(valid), .power_up_request(req));
  swb_rx i_swb_rx_b (.clk, .rst_n, .link(bad), .enable, .over_temp,
    .brightness_code(bright_b), .code_valid(), .power_up_request());
  swb_assertions i_swb_assertions (.clk, .rst_n, .data_o(link.data_o),
    .data_oe(link.data_oe), .data_line(link.data_line));
  always @(posedge clk)
    if (valid === 1'b1)
      nvalid++;
  // ==========================================================
  // Tasks
  task chk(input logic [4:0] seen, input logic [4:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("Errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task tx_send(input logic [4:0] c);
    int n;
    n = nvalid;
    code = c;
    send = 1'b1;
    cyc(1);
    send = 1'b0;
    for (int i = 0; i < 20000 && busy !== 1'b0; i++)
      cyc(1);
    chk(5'(busy), 5'h0);
    chk(bright, c);
    chk(5'(nvalid - n), 5'h1);
    chk(5'(req), 5'(c != 5'h0));
  endtask : tx_send
  // Phases of 30/90 cycles keep the 25% share but differ from the host's
  // 25/75, so the decision rests on the comparison, not on fixed counts.
  task raw(input logic [7:0] b, input int n);
    for (int i = 0; i <= n; i++)
    begin
      bad.data_oe = 1'b1;
      cyc(i == n ? 75 : (b[i] ? 30 : 90));
      bad.data_oe = 1'b0;
      cyc(i == n ? 5100 : (b[i] ? 90 : 30));
    end
  endtask : raw
  // ==========================================================
  // Sequence
  initial
  begin
    bad.data_o = 1'b0;
    bad.data_oe = 1'b0;
    cyc(20);
    rst_n = 1'b1;
    chk(bright, 5'h1f);
    chk(5'(req), 5'h0);
    foreach (codes[k])
      tx_send(codes[k]);
    enable = 1'b1;
    cyc(5);
    chk(5'(req), 5'h1);
    enable = 1'b0;
    cyc(5);
    chk(5'(req), 5'h0);
    over_temp = 1'b1;
    cyc(3);
    over_temp = 1'b0;
    cyc(3);
    chk(bright, 5'h1f);
    tx_send(5'h0c);
    raw(8'h05, 3);
    chk(bright_b, 5'h1f);
    raw(8'h69, 7);
    chk(bright_b, 5'h09);
    end_sim();
  end
  initial
  begin
    cyc(60000);
    num_errors++;
    end_sim();
  end
endmodule : single_wire_brightness_receiver_tb

//--- swb_assertions.sv
// Purpose: Wire-level checks on the host-to-receiver link.
// Assumes: Host phases of 25 or 75 cycles, stop low of 75 cycles.
// Notes: Idle counter starts saturated so reset never looks like a gap.
`timescale 1ns/1ps
module swb_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic data_o,
  input wire logic data_oe,
  input wire logic data_line
);
  localparam logic [12:0] GAP = 13'(swb_pkg::RESET_CYC);
  logic [12:0] lo_r;
  logic [12:0] hi_r;
  logic [12:0] last_lo_r;
  logic [2:0] rises_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Phase counters
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      lo_r <= 13'h0;
      hi_r <= 13'h1fff;
    end
    else
    begin
      lo_r <= data_oe ? lo_r + 13'h1 : 13'h0;
      hi_r <= data_oe ? 13'h0 : hi_r + {12'h0, hi_r != 13'h1fff};
    end
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      last_lo_r <= 13'h0;
      rises_r <= 3'h0;
    end
    else
    begin
      if (!data_oe && lo_r != 13'h0)
        last_lo_r <= lo_r;
      if (data_oe && hi_r != 13'h0)
        rises_r <= rises_r + 3'h1;
      else if (hi_r == GAP)
        rises_r <= 3'h0;
    end
  // ==========================================================
  // Properties
  AST_DRIVE_LOW: assert property (data_oe |-> !data_o && !data_line)
    else $error("driven wire not low");
  AST_IDLE_HIGH: assert property (!data_oe |-> data_line)
    else $error("released wire not high");
  AST_LOW_LEN: assert property ($fell(data_oe) |-> lo_r inside {25, 75})
    else $error("low phase length wrong");
  AST_HIGH_LEN: assert property ($rose(data_oe) |->
    hi_r inside {25, 75} || hi_r >= GAP)
    else $error("high phase length wrong");
  AST_FIVE_BITS: assert property (hi_r == GAP |-> rises_r == 3'h6)
    else $error("frame is not five bits and stop");
  AST_STOP_LOW: assert property ($fell(data_oe) && rises_r == 3'h6
    |-> lo_r == 13'd75)
    else $error("stop pulse length wrong");
  AST_PERIOD: assert property ($rose(data_oe) && rises_r != 3'h0
    |-> last_lo_r + hi_r == 13'd100)
    else $error("bit period wrong");
  AST_LOW_BOUND: assert property ($rose(data_oe)
    |-> ##[25:75] $fell(data_oe))
    else $error("low phase not ended in time");
  COV_START: cover property ($rose(data_oe) && rises_r == 3'h0);
  COV_STOP: cover property ($fell(data_oe) && rises_r == 3'h6);
  COV_GAP: cover property (hi_r == GAP);
endmodule : swb_assertions

//--- swb_if.sv
// Purpose: Single data wire between host and receiver.
// Assumes: Host drives open-drain style; idle line is pulled high.
// Notes: The wire level is resolved here from the host enable.
`timescale 1ns/1ps
interface swb_if;
  logic data_o;
  logic data_oe;
  logic data_line;
  assign data_line = data_oe ? data_o : 1'b1;
  modport host (output data_o, output data_oe, input data_line);
  modport dev (input data_line);
endinterface : swb_if

//--- swb_pkg.sv
// Purpose: Shared constants for the single-wire brightness link.
// Assumes: 50 MHz clock on both ends.
// Notes: Times are in nanoseconds; cycle counts derive from them.
package swb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned CODE_BITS = 5;
  localparam logic [4:0] CODE_RESET = 5'h1f;
  localparam int unsigned T_LOW_MIN_NS = 500;
  localparam int unsigned T_LONG_MIN_NS = 1500;
  localparam int unsigned T_SHORT_MAX_NS = 13000;
  localparam int unsigned T_RESET_NS = 100000;
  // Least times round up, longest times round down.
  localparam int unsigned LOW_MIN_CYC =
    (T_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LONG_MIN_CYC =
    (T_LONG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_MAX_CYC = T_SHORT_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned RESET_CYC =
    (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host phase lengths: short 25, long 75 cycles, inside every window.
  localparam int unsigned HOST_SHORT_CYC = 25;
  localparam int unsigned HOST_LONG_CYC = 75;
  localparam int unsigned CNT_W = 13;
endpackage : swb_pkg

//--- swb_rx.sv
// Purpose: Receiver end: decodes brightness commands from the wire.
// Assumes: Host keeps its own timing windows.
// Notes: Over-temperature acts as a synchronous hold in reset.
`timescale 1ns/1ps
// Function
// - Bits arrive and assemble LSB first.
// - Frame starts at a falling edge.
// - Longer high gives one, longer low zero.
// - Host keeps 75/25 duty per bit.
// - Host phases 500 ns to 40 us.
// - Host bit period 2 us to 53 us.
// - Bit latched at ending fall; stop pulse follows.
// - Five bits load code at stop rise.
// - Long idle high resets bit counter.
// - Partial frame discarded on counter reset.
// - Sixth bit rise loads; later bits ignored.
// - Over-temperature holds logic in reset.
// - Brightness code powers up at 31.
// - Enable rise or nonzero code requests power.
// - Enable fall or zero code drops request.
module swb_rx (
  input wire logic clk,
  input wire logic rst_n,
  swb_if.dev link,
  input wire logic enable,
  input wire logic over_temp,
  output logic [4:0] brightness_code,
  output logic code_valid,
  output logic power_up_request
);
  localparam int unsigned CW = swb_pkg::CNT_W;

  // ==========================================================
  // Input synchronisation
  logic data_s;
  logic en_s;
  logic en_n_s;
  logic prev_r;
  logic en_prev_r;
  swb_sync u_sync_data (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.data_line),
    .q(data_s)
  );
  // The enable pin idles low while the synchroniser resets high, so the pin
  // goes through inverted; otherwise every reset would look like a rise.
  swb_sync u_sync_en (
    .clk(clk),
    .rst_n(rst_n),
    .d(~enable),
    .q(en_n_s)
  );
  assign en_s = ~en_n_s;

  logic fall;
  logic rise;
  assign fall = prev_r & ~data_s;
  assign rise = ~prev_r & data_s;

  logic en_rise;
  logic en_fall;
  assign en_rise = en_s & ~en_prev_r;
  assign en_fall = ~en_s & en_prev_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_r <= 1'b1;
    else
      prev_r <= data_s;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      en_prev_r <= 1'b0;
    else
      en_prev_r <= en_s;
  end

  // ==========================================================
  // Phase measurement
  logic [CW-1:0] low_cnt_r;
  logic [CW-1:0] high_cnt_r;
  logic [CW-1:0] idle_cnt_r;
  logic in_frame_r;
  logic idle_reset;
  // Idle time counts on the synchronised line; the longest high phase of a
  // bit stays far below the reset span, so only a real pause ends a frame.
  assign idle_reset = data_s && (idle_cnt_r >= CW'(swb_pkg::RESET_CYC));

  // Counters saturate so a stuck line cannot wrap into a false bit.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_cnt_r <= '0;
      high_cnt_r <= '0;
      idle_cnt_r <= '0;
    end
    else if (over_temp)
    begin
      low_cnt_r <= '0;
      high_cnt_r <= '0;
      idle_cnt_r <= '0;
    end
    else
    begin
      if (fall)
      begin
        low_cnt_r <= CW'(1);
        high_cnt_r <= '0;
      end
      else if (!data_s && low_cnt_r != '1)
        low_cnt_r <= low_cnt_r + CW'(1);
      else if (data_s && high_cnt_r != '1)
        high_cnt_r <= high_cnt_r + CW'(1);
      if (!data_s)
        idle_cnt_r <= '0;
      else if (idle_cnt_r != '1)
        idle_cnt_r <= idle_cnt_r + CW'(1);
    end
  end

  // ==========================================================
  // Bit assembly
  logic [4:0] shift_r;
  logic [2:0] nbits_r;
  logic loaded_r;
  logic bit_val;
  assign bit_val = high_cnt_r > low_cnt_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_r <= '0;
      nbits_r <= '0;
      in_frame_r <= 1'b0;
    end
    else if (over_temp || idle_reset)
    begin
      shift_r <= '0;
      nbits_r <= '0;
      in_frame_r <= 1'b0;
    end
    else if (fall)
    begin
      in_frame_r <= 1'b1;
      if (in_frame_r && nbits_r < 3'(swb_pkg::CODE_BITS + 1))
      begin
        nbits_r <= nbits_r + 3'h1;
        if (nbits_r < 3'(swb_pkg::CODE_BITS))
          shift_r <= {bit_val, shift_r[4:1]};
      end
    end
  end

  // ==========================================================
  // Code register and power request
  // The stop pulse and the sixth bit of an overlong frame look alike here:
  // both rise after five bits are counted, and loaded_r allows one load.
  logic load;
  assign load = rise && !loaded_r && in_frame_r &&
    nbits_r == 3'(swb_pkg::CODE_BITS);

  // Over-temperature clears counters, bits and outputs (not the synchronisers), so the code returns to its
  // power-up value and a frame in flight is lost with it.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brightness_code <= swb_pkg::CODE_RESET;
      code_valid <= 1'b0;
      loaded_r <= 1'b0;
    end
    else if (over_temp)
    begin
      brightness_code <= swb_pkg::CODE_RESET;
      code_valid <= 1'b0;
      loaded_r <= 1'b0;
    end
    else
    begin
      code_valid <= load;
      if (idle_reset)
        loaded_r <= 1'b0;
      else if (load)
      begin
        loaded_r <= 1'b1;
        brightness_code <= shift_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      power_up_request <= 1'b0;
    else if (over_temp)
      power_up_request <= 1'b0;
    else if (en_rise)
      power_up_request <= 1'b1;
    else if (en_fall)
      power_up_request <= 1'b0;
    else if (load)
      power_up_request <= (shift_r != 5'h00);
  end
endmodule : swb_rx

//--- swb_sync.sv
// Purpose: Two-flop synchroniser for the data wire and the inverted enable pin.
// Assumes: Line idles high.
// Notes: Output only comes from the second flop.
`timescale 1ns/1ps
module swb_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b1;
      q <= 1'b1;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : swb_sync

//--- swb_tx.sv
// Purpose: Host end: sends one 5-bit brightness command per request.
// Assumes: Line rests high; frame ends with stop pulse then reset idle.
// Notes: Busy covers the trailing idle so frames never merge.
`timescale 1ns/1ps
module swb_tx (
  input wire logic clk,
  input wire logic rst_n,
  swb_if.host link,
  input wire logic send,
  input wire logic [4:0] code,
  output logic busy
);
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_LOW = 5'h02,
    S_HIGH = 5'h04,
    S_STOP = 5'h08,
    S_GAP = 5'h10
  } swb_tx_e;
  swb_tx_e st_r;
  logic [4:0] sh_r;
  logic [2:0] bit_r;
  logic [12:0] cnt_r;

  // Zero: 75 low, 25 high; one: reverse.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= S_IDLE;
      sh_r <= '0;
      bit_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      case (st_r)
        S_IDLE:
          if (send)
          begin
            sh_r <= code;
            bit_r <= '0;
            cnt_r <= code[0] ? 13'(swb_pkg::HOST_SHORT_CYC - 1) :
              13'(swb_pkg::HOST_LONG_CYC - 1);
            st_r <= S_LOW;
          end
        S_LOW:
          if (cnt_r == '0)
          begin
            cnt_r <= sh_r[0] ? 13'(swb_pkg::HOST_LONG_CYC - 1) :
              13'(swb_pkg::HOST_SHORT_CYC - 1);
            st_r <= S_HIGH;
          end
          else
            cnt_r <= cnt_r - 13'h1;
        S_HIGH:
          if (cnt_r != '0)
            cnt_r <= cnt_r - 13'h1;
          else if (bit_r == 3'(swb_pkg::CODE_BITS - 1))
          begin
            cnt_r <= 13'(swb_pkg::HOST_LONG_CYC - 1);
            st_r <= S_STOP;
          end
          else
          begin
            bit_r <= bit_r + 3'h1;
            sh_r <= {1'b0, sh_r[4:1]};
            cnt_r <= sh_r[1] ? 13'(swb_pkg::HOST_SHORT_CYC - 1) :
              13'(swb_pkg::HOST_LONG_CYC - 1);
            st_r <= S_LOW;
          end
        S_STOP:
          if (cnt_r == '0)
          begin
            cnt_r <= 13'(swb_pkg::RESET_CYC + 8);
            st_r <= S_GAP;
          end
          else
            cnt_r <= cnt_r - 13'h1;
        S_GAP:
          if (cnt_r == '0)
            st_r <= S_IDLE;
          else
            cnt_r <= cnt_r - 13'h1;
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  assign link.data_o = 1'b0;
  assign link.data_oe = (st_r == S_LOW) || (st_r == S_STOP);
  assign busy = (st_r != S_IDLE);
endmodule : swb_tx
